// ### logic/codec_nibble_destacker.sv
`timescale 1ns/1ps
// Summary of operation
// - processor write to location 10h queues the byte; a later codec slot pops it into low and high latches
// - in synthesis mode low output enable asserts while odd phase is low
// - low output enable drives the lower four bits onto codec data lines
// - upper nibble is held in its own latch, not driven during low nibble
// - low odd phase pulses set-interrupt, setting the active-low codec interrupt
// - codec interrupt means a byte was handed to the codec for decoding
// - codec clock edge after low odd phase asserts high enable, upper nibble out
// - in analysis mode both decode latches keep their outputs disabled
// - write to location 10h acknowledges and clears the interrupt flip-flop, unless a set pulse comes in the same cycle

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 count;
	} fifo_s;

	fifo_s state_reg;
	fifo_s state_next;
	logic  push;
	logic  pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign o_in_ready  = (state_reg.count != (AW+1)'(DEPTH));
	assign o_out_valid = (state_reg.count != '0);
	assign o_out_data  = state_reg.mem[state_reg.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wr] = i_in_data;
			state_next.wr                = bump(state_reg.wr);
		end
		if (pop) begin
			state_next.rd = bump(state_reg.rd);
		end
		if (push && !pop) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (pop && !push) begin
			state_next.count = state_reg.count - 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	property p_fifo_no_overfill;
		@(posedge i_clock) disable iff (!i_rst_n)
		state_reg.count <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_no_overfill: assert property (p_fifo_no_overfill)
		else $error("fifo count above depth");
endmodule : byte_fifo

module codec_nibble_destacker #(
	parameter int DEPTH = destacker_pkg::FIFO_DEPTH
) (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_cpu_addr,
	input  wire logic [7:0] i_cpu_data,
	input  wire logic       i_cpu_write,
	output logic            o_cpu_ready,
	input  wire logic       i_codec_clock_en,
	input  wire logic       i_analysis_mode_flag,
	output logic [3:0]      o_codec_nibble,
	output logic            o_codec_nibble_oe,
	output logic            o_low_nibble_out_en_n,
	output logic            o_high_nibble_out_en_n,
	output logic            o_irq_set_pulse_n,
	output logic            o_codec_irq_n
);
	typedef struct packed {
		destacker_pkg::phase_e phase;
		logic [3:0]            low_latch;
		logic [3:0]            high_latch;
		logic                  irq;
		logic                  set_pulse;
		destacker_pkg::nibble_bus_s bus;
	} dst_s;

	dst_s                 state_reg;
	dst_s                 state_next;
	logic                 codec_byte_write;
	logic                 codec_ack_strobe;
	logic                 fifo_valid;
	logic                 fifo_pop;
	logic [7:0]           fifo_data;

	assign codec_byte_write = i_cpu_write && (i_cpu_addr == destacker_pkg::CODEC_PORT_ADDR);
	// the same write both delivers the next byte and acknowledges the last one
	assign codec_ack_strobe = codec_byte_write;

	byte_fifo #(
		.WIDTH(destacker_pkg::DATA_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clock    (i_clock),
		.i_rst_n    (i_rst_n),
		.i_in_valid (codec_byte_write),
		.o_in_ready (o_cpu_ready),
		.i_in_data  (i_cpu_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data (fifo_data)
	);

	// a byte is taken only at a codec slot in synthesis mode while the phase is idle or high
	// never during the low slot: a pop there would overwrite the high nibble before it is shown
	assign fifo_pop = fifo_valid && i_codec_clock_en && !i_analysis_mode_flag
		&& (state_reg.phase != destacker_pkg::PH_LOW);

	always_comb begin
		state_next           = state_reg;
		state_next.set_pulse = 1'b0;
		if (i_codec_clock_en) begin
			case (state_reg.phase)
				destacker_pkg::PH_HIGH: begin
					state_next.phase = fifo_pop ? destacker_pkg::PH_LOW : destacker_pkg::PH_IDLE;
				end
				default: begin
					if (fifo_pop) begin
						state_next.phase = destacker_pkg::PH_LOW;
					end else if (state_reg.phase == destacker_pkg::PH_LOW) begin
						state_next.phase = destacker_pkg::PH_HIGH;
					end else begin
						state_next.phase = destacker_pkg::PH_IDLE;
					end
				end
			endcase
			if (fifo_pop) begin
				state_next.low_latch  = fifo_data[3:0];
				state_next.high_latch = fifo_data[7:4];
			end
			if (state_reg.phase == destacker_pkg::PH_LOW && !fifo_pop) begin
				state_next.phase = destacker_pkg::PH_HIGH;
			end
		end
		if (i_analysis_mode_flag) begin
			state_next.phase = destacker_pkg::PH_IDLE;
		end
		if (state_next.phase == destacker_pkg::PH_LOW && state_reg.phase != destacker_pkg::PH_LOW) begin
			state_next.set_pulse = 1'b1;
		end
		// ack clears; set wins over clear
		if (codec_ack_strobe) begin
			state_next.irq = 1'b0;
		end
		if (state_next.set_pulse) begin
			state_next.irq = 1'b1;
		end
		state_next.bus.low_en_n  = !(state_next.phase == destacker_pkg::PH_LOW) || i_analysis_mode_flag;
		state_next.bus.high_en_n = !(state_next.phase == destacker_pkg::PH_HIGH) || i_analysis_mode_flag;
		if (!state_next.bus.high_en_n) begin
			state_next.bus.data = state_next.high_latch;
		end else if (!state_next.bus.low_en_n) begin
			state_next.bus.data = state_next.low_latch;
		end else begin
			state_next.bus.data = destacker_pkg::NIBBLE_RESET;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg               <= '0;
			state_reg.phase         <= destacker_pkg::PH_IDLE;
			state_reg.bus.low_en_n  <= 1'b1;
			state_reg.bus.high_en_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_codec_nibble         = state_reg.bus.data;
	assign o_low_nibble_out_en_n  = state_reg.bus.low_en_n;
	assign o_high_nibble_out_en_n = state_reg.bus.high_en_n;
	assign o_codec_nibble_oe      = !(state_reg.bus.low_en_n && state_reg.bus.high_en_n);
	assign o_irq_set_pulse_n      = !state_reg.set_pulse;
	assign o_codec_irq_n          = !state_reg.irq;

	property p_analysis_quiet;
		@(posedge i_clock) disable iff (!i_rst_n)
		$past(i_analysis_mode_flag) |-> (o_low_nibble_out_en_n && o_high_nibble_out_en_n);
	endproperty
	a_analysis_quiet: assert property (p_analysis_quiet)
		else $error("decode latch enabled in analysis mode");

	property p_enables_exclusive;
		@(posedge i_clock) disable iff (!i_rst_n)
		!(!o_low_nibble_out_en_n && !o_high_nibble_out_en_n);
	endproperty
	a_enables_exclusive: assert property (p_enables_exclusive)
		else $error("both nibble enables active");

	property p_low_data;
		@(posedge i_clock) disable iff (!i_rst_n)
		!o_low_nibble_out_en_n |-> (o_codec_nibble == state_reg.low_latch);
	endproperty
	a_low_data: assert property (p_low_data)
		else $error("low nibble not driven");

	property p_high_follows;
		@(posedge i_clock) disable iff (!i_rst_n)
		(!o_low_nibble_out_en_n && i_codec_clock_en && !i_analysis_mode_flag && !fifo_pop)
			|=> (!o_high_nibble_out_en_n && o_codec_nibble == state_reg.high_latch);
	endproperty
	a_high_follows: assert property (p_high_follows)
		else $error("high nibble did not follow low");

	property p_high_one_slot;
		@(posedge i_clock) disable iff (!i_rst_n)
		(!o_high_nibble_out_en_n && i_codec_clock_en) |=> o_high_nibble_out_en_n;
	endproperty
	a_high_one_slot: assert property (p_high_one_slot)
		else $error("high nibble held past its slot");

	property p_irq_set;
		@(posedge i_clock) disable iff (!i_rst_n)
		!o_irq_set_pulse_n |-> !o_codec_irq_n;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("set pulse without interrupt");

	property p_irq_clear;
		@(posedge i_clock) disable iff (!i_rst_n)
		(codec_ack_strobe && !state_next.set_pulse) |=> o_codec_irq_n;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("ack did not clear interrupt");

	property p_irq_cause;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(o_codec_irq_n) |-> !o_irq_set_pulse_n;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without handed byte");

	property p_write_lands;
		@(posedge i_clock) disable iff (!i_rst_n)
		(codec_byte_write && o_cpu_ready) |=> fifo_valid;
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("accepted byte not stored");

	property p_low_entry_sets;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(o_low_nibble_out_en_n) |-> !o_irq_set_pulse_n;
	endproperty
	a_low_entry_sets: assert property (p_low_entry_sets)
		else $error("low slot opened without set pulse");

	property p_set_wins;
		@(posedge i_clock) disable iff (!i_rst_n)
		(codec_ack_strobe && state_next.set_pulse) |=> !o_codec_irq_n;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("ack beat a new interrupt");

	property p_high_from_low;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(o_high_nibble_out_en_n) |-> !$past(o_low_nibble_out_en_n);
	endproperty
	a_high_from_low: assert property (p_high_from_low)
		else $error("high slot without preceding low slot");

	property p_no_pop_in_low;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_reg.phase == destacker_pkg::PH_LOW) |-> !fifo_pop;
	endproperty
	a_no_pop_in_low: assert property (p_no_pop_in_low)
		else $error("byte taken during low slot");
endmodule : codec_nibble_destacker

// ### logic/destacker_pkg.sv
package destacker_pkg;
	localparam int DATA_WIDTH   = 8;
	localparam int NIBBLE_WIDTH = 4;
	localparam int FIFO_DEPTH   = 8;
	// external location of the codec byte port
	localparam logic [7:0] CODEC_PORT_ADDR = 8'h10;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic [3:0] NIBBLE_RESET    = 4'h0;

	typedef enum logic [1:0] {
		PH_LOW  = 2'b00,
		PH_HIGH = 2'b01,
		PH_IDLE = 2'b11
	} phase_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_s;

	typedef struct packed {
		logic       low_en_n;
		logic       high_en_n;
		logic [3:0] data;
	} nibble_bus_s;
endpackage : destacker_pkg

// ### test/codec_model.sv
`timescale 1ns/1ps
// codec end: one clock enable every i_gap cycles, 0 holds the codec clock still
module codec_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_gap,
	input  wire logic [3:0] i_nibble,
	input  wire logic       i_oe,
	input  wire logic       i_high_en_n,
	output logic            o_clock_en
);
	logic [4:0] seen[$];
	int         cnt = 0;
	always @(negedge i_clock) begin
		cnt = cnt + 1;
		o_clock_en <= 1'b0;
		if (i_gap != 8'h00 && cnt >= int'(i_gap)) begin
			cnt = 0;
			o_clock_en <= 1'b1;
			// nibble is taken as the phase ends
			if (i_oe === 1'b1)
				seen.push_back({~i_high_en_n, i_nibble});
		end
	end
endmodule : codec_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic       i_clock = 1'b0;
	logic       i_rst_n = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, gap = 8'h00;
	logic       wr = 1'b0, ana = 1'b0, ana_q = 1'b0, prev_low_n = 1'b1;
	logic [3:0] nib;
	logic       oe, rdy, clk_en, low_n, high_n, set_n, irq_n;
	logic [4:0] exp_q[$];
	int         n_errors = 0, checks = 0, cycles = 0, acc = 0;
	always #4 i_clock = ~i_clock;
	codec_nibble_destacker dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cpu_addr(addr), .i_cpu_data(wdata),
		.i_cpu_write(wr), .o_cpu_ready(rdy), .i_codec_clock_en(clk_en), .i_analysis_mode_flag(ana),
		.o_codec_nibble(nib), .o_codec_nibble_oe(oe), .o_low_nibble_out_en_n(low_n),
		.o_high_nibble_out_en_n(high_n), .o_irq_set_pulse_n(set_n), .o_codec_irq_n(irq_n));
	codec_model u_codec (.i_clock(i_clock), .i_gap(gap), .i_nibble(nib), .i_oe(oe), .i_high_en_n(high_n),
		.o_clock_en(clk_en));
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	function automatic logic [4:0] slot(input logic [7:0] b, input logic hi);
		return {hi, hi ? b[7:4] : b[3:0]};
	endfunction : slot
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// strobe stays up so writes can run back to back
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		addr = a;
		wdata = d;
		wr = 1'b1;
		if (a == destacker_pkg::CODEC_PORT_ADDR && rdy === 1'b1) begin
			exp_q.push_back(slot(d, 1'b0));
			exp_q.push_back(slot(d, 1'b1));
			acc++;
		end
	endtask : put
	task automatic idle(input int n);
		@(negedge i_clock);
		wr = 1'b0;
		repeat (n) @(negedge i_clock);
	endtask : idle
	task automatic drain();
		int i;
		i = 0;
		while (u_codec.seen.size() < exp_q.size() && i < 3000) begin
			@(negedge i_clock);
			i++;
		end
		repeat (12) @(negedge i_clock);
		chk("nibble count", 8'(exp_q.size()), 8'(u_codec.seen.size()));
		while (exp_q.size() > 0 && u_codec.seen.size() > 0)
			chk("nibble", 8'(exp_q.pop_front()), 8'(u_codec.seen.pop_front()));
		exp_q.delete();
		u_codec.seen.delete();
	endtask : drain
	always @(posedge i_clock) begin
		ana_q <= ana;
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	always @(negedge i_clock) begin
		if (low_n === 1'b0 && prev_low_n === 1'b1) begin
			chk("set pulse", 8'h00, {7'h0, set_n});
			chk("irq", 8'h00, {7'h0, irq_n});
		end
		if (ana_q === 1'b1)
			chk("enables", 8'h03, {6'h0, low_n, high_n});
		prev_low_n = low_n;
	end
	initial begin
		void'($urandom(32'h9faa));
		repeat (12) @(negedge i_clock);
		i_rst_n = 1'b1;
		put(destacker_pkg::CODEC_PORT_ADDR, 8'ha5);
		idle(1);
		gap = 8'd2;
		idle(12);
		gap = 8'd0;
		chk("irq held", 8'h00, {7'h0, irq_n});
		put(8'h11, 8'h3c);
		idle(0);
		chk("irq other addr", 8'h00, {7'h0, irq_n});
		put(destacker_pkg::CODEC_PORT_ADDR, 8'h5a);
		idle(0);
		chk("irq ack", 8'h01, {7'h0, irq_n});
		gap = 8'd2;
		drain();
		gap = 8'd0;
		acc = 0;
		repeat (10) put(destacker_pkg::CODEC_PORT_ADDR, 8'($urandom));
		chk("accepted", 8'(destacker_pkg::FIFO_DEPTH), 8'(acc));
		chk("ready full", 8'h00, {7'h0, rdy});
		idle(0);
		gap = 8'd1;
		drain();
		ana = 1'b1;
		idle(20);
		ana = 1'b0;
		put(destacker_pkg::CODEC_PORT_ADDR, 8'hf0);
		idle(0);
		drain();
		repeat (300) begin
			gap = 8'($urandom_range(1, 4));
			put(($urandom_range(0, 5) == 0) ? 8'($urandom) : destacker_pkg::CODEC_PORT_ADDR, 8'($urandom));
			if ($urandom_range(0, 2) == 0)
				idle($urandom_range(0, 3));
		end
		idle(0);
		drain();
		wrap_up();
	end
endmodule : testbench
